// *** hdl/ibx_core.sv ***
`timescale 1ns/100ps
`include "ibx_regs.svh"
module ibx_core #(
	parameter int PC_WIDTH = 11
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic [11:0] fetch_insn_in,
	input wire logic [7:0] file_rdata_in,
	input wire logic [7:0] status_in,
	output logic [4:0] file_raddr_out,
	output ibx_pkg::ibx_fwr_type file_wr_out,
	output logic zero_we_out,
	output logic zero_val_out,
	output logic [7:0] accum_out,
	output logic [PC_WIDTH-1:0] pc_out,
	output logic flush_out,
	output logic [11:0] exec_insn_out
);
	import ibx_pkg::*;
	// Counter arithmetic and branch target are built for 11 bits
	if (PC_WIDTH != 11) begin : g_pc_width_check
		$error("PC_WIDTH must be 11");
	end
	ibx_dec_type dec;
	logic [7:0] accum, next_accum;
	logic [PC_WIDTH-1:0] pc, next_pc;
	logic flush, next_flush;
	ibx_fwr_type fwr, next_fwr;
	logic zwe, next_zwe, zval, next_zval;
	logic [11:0] exec_insn;
	logic [7:0] result;
	// Flushed slot executes a no-operation
	assign exec_insn = flush ? `IBX_INSN_NOP : fetch_insn_in;
	ibx_decode u_dec (
		.insn_in(exec_insn),
		.dec_out(dec)
	);
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero
	assign file_raddr_out = dec.file_addr;
	always_comb begin
		next_accum = accum;
		next_pc = pc + 11'h001;
		next_flush = 1'b0;
		next_fwr = '0;
		next_zwe = 1'b0;
		next_zval = 1'b0;
		result = 8'h00;
		unique case (dec.op)
			IBX_OP_INCR_FILE, IBX_OP_INCR_SKIP: begin
				result = file_rdata_in + 8'h01;
				if (dec.dest_file) begin
					next_fwr = '{we: 1'b1, addr: dec.file_addr, data: result};
				end else begin
					next_accum = result;
				end
				if (dec.op == IBX_OP_INCR_FILE) begin
					next_zwe = 1'b1;
					next_zval = is_zero(result);
				end else begin
					// Flags untouched, skip only on zero
					next_flush = is_zero(result);
				end
			end
			IBX_OP_BRANCH: begin
				// Page bits from status; prefetch is stale, so flush
				next_pc = {status_in[`IBX_PAGE_HI:`IBX_PAGE_LO],
					dec.imm};
				next_flush = 1'b1;
			end
			IBX_OP_OR_LIT: begin
				result = accum | dec.imm[7:0];
				next_accum = result;
				next_zwe = 1'b1;
				next_zval = is_zero(result);
			end
			IBX_OP_OR_FILE: begin
				result = accum | file_rdata_in;
				if (dec.dest_file) begin
					next_fwr = '{we: 1'b1, addr: dec.file_addr, data: result};
				end else begin
					next_accum = result;
				end
				next_zwe = 1'b1;
				next_zval = is_zero(result);
			end
			IBX_OP_NONE: begin
			end
		endcase
	end
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			accum <= `IBX_ACCUM_RESET;
			pc <= `IBX_PC_RESET;
			flush <= 1'b0;
			fwr <= '0;
			zwe <= 1'b0;
			zval <= 1'b0;
		end else begin
			accum <= next_accum;
			pc <= next_pc;
			flush <= next_flush;
			fwr <= next_fwr;
			zwe <= next_zwe;
			zval <= next_zval;
		end
	end
	assign accum_out = accum;
	assign pc_out = pc;
	assign flush_out = flush;
	assign file_wr_out = fwr;
	assign zero_we_out = zwe;
	assign zero_val_out = zval;
	assign exec_insn_out = exec_insn;

	a_incr_zero_flag: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_FILE
		|=> zwe && zval == (($past(file_rdata_in) + 8'h01) == 8'h00))
		else $error("increment zero flag wrong");

	a_incr_to_accum: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_FILE && !dec.dest_file
		|=> !fwr.we && accum == $past(file_rdata_in) + 8'h01)
		else $error("increment to accumulator wrong");

	a_incr_to_file: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_FILE && dec.dest_file
		|=> fwr.we && fwr.addr == $past(fetch_insn_in[4:0])
		&& fwr.data == $past(file_rdata_in) + 8'h01
		&& accum == $past(accum))
		else $error("increment to file wrong");

	a_skip_no_flags: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_SKIP
		|=> !zwe)
		else $error("increment-skip touched a flag");

	a_skip_to_file: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_SKIP && dec.dest_file
		|=> fwr.we && fwr.data == $past(file_rdata_in) + 8'h01
		&& accum == $past(accum))
		else $error("increment-skip to file wrong");

	a_skip_to_accum: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_SKIP && !dec.dest_file
		|=> !fwr.we && accum == $past(file_rdata_in) + 8'h01)
		else $error("increment-skip to accumulator wrong");

	a_skip_taken: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_SKIP && file_rdata_in == 8'hFF
		|=> flush && exec_insn == 12'h000)
		else $error("skip not taken");

	a_skip_not_taken: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_INCR_SKIP && file_rdata_in != 8'hFF
		|=> !flush)
		else $error("skip taken on nonzero result");

	a_flush_no_trace: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		flush
		|=> !zwe && !fwr.we && accum == $past(accum))
		else $error("discarded word left a trace");

	a_branch_target: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_BRANCH
		|=> pc[8:0] == $past(fetch_insn_in[8:0]))
		else $error("branch target wrong");

	a_branch_page: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_BRANCH
		|=> pc[10:9] == $past(status_in[6:5]))
		else $error("branch page bits wrong");

	a_branch_no_flag: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_BRANCH
		|=> !zwe && !fwr.we && accum == $past(accum))
		else $error("branch changed state");

	a_branch_two_cyc: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_BRANCH
		|=> flush ##1 !flush)
		else $error("branch not two cycles");

	a_orlit_accum: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_OR_LIT
		|=> accum == ($past(accum) | $past(fetch_insn_in[7:0])) && zwe)
		else $error("or literal wrong");

	a_orlit_zero: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_OR_LIT
		|=> zval == (accum == 8'h00))
		else $error("or literal zero flag wrong");

	a_orfile_to_file: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_OR_FILE && dec.dest_file
		|=> fwr.we && fwr.addr == $past(fetch_insn_in[4:0])
		&& fwr.data == ($past(accum) | $past(file_rdata_in))
		&& accum == $past(accum) && zwe)
		else $error("or file to file wrong");

	a_orfile_to_accum: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_OR_FILE && !dec.dest_file
		|=> !fwr.we && accum == ($past(accum) | $past(file_rdata_in)))
		else $error("or file to accumulator wrong");

	a_orfile_zero: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op == IBX_OP_OR_FILE
		|=> zwe && zval == (($past(accum) | $past(file_rdata_in)) == 8'h00))
		else $error("or file zero flag wrong");

	a_one_cycle: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op inside {IBX_OP_INCR_FILE, IBX_OP_OR_LIT, IBX_OP_OR_FILE}
		|=> !flush)
		else $error("single cycle op stalled");

	a_pc_step: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dec.op != IBX_OP_BRANCH
		|=> pc == $past(pc) + 11'h001)
		else $error("counter did not step by one");
endmodule : ibx_core

// *** hdl/ibx_regs.svh ***
`ifndef IBX_REGS_SVH
`define IBX_REGS_SVH
// What this block does
// - Increment file 0..31; d=0 result to accumulator, d=1 back to file.
// - Increment-skip: same destination choice, all status flags unchanged.
// - Zero skip result drops prefetched word; a no-operation runs instead.
// - Branch loads 9-bit immediate 0..511 into program counter bits 8..0.
// - Branch fills counter bits 10..9 from status 6..5; flags unchanged.
// - Branch takes two instruction cycles.
// - OR literal 0..255 into accumulator; zero flag updated.
// - OR accumulator with file 0..31; zero updated; d selects destination.
`define IBX_OPC_INCR_FILE 6'h0A
`define IBX_OPC_INCR_SKIP 6'h0F
`define IBX_OPC_OR_FILE 6'h04
`define IBX_OPC_BRANCH 3'h5
`define IBX_OPC_OR_LIT 4'hD
`define IBX_INSN_NOP 12'h000
`define IBX_ZERO_BIT 2
`define IBX_PAGE_HI 6
`define IBX_PAGE_LO 5
`define IBX_ACCUM_RESET 8'h00
`define IBX_PC_RESET 11'h7FF
`endif

// *** hdl/ibx_pkg.sv ***
package ibx_pkg;
	typedef enum logic [2:0] {
		IBX_OP_NONE,
		IBX_OP_INCR_FILE,
		IBX_OP_INCR_SKIP,
		IBX_OP_BRANCH,
		IBX_OP_OR_LIT,
		IBX_OP_OR_FILE
	} ibx_op_type;
	typedef struct packed {
		ibx_op_type op;
		logic dest_file;
		logic [4:0] file_addr;
		logic [8:0] imm;
	} ibx_dec_type;
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} ibx_fwr_type;
endpackage : ibx_pkg

// *** hdl/ibx_decode.sv ***
`timescale 1ns/100ps
`include "ibx_regs.svh"
module ibx_decode (
	input wire logic [11:0] insn_in,
	output ibx_pkg::ibx_dec_type dec_out
);
	import ibx_pkg::*;
	always_comb begin
		dec_out.op = IBX_OP_NONE;
		dec_out.dest_file = insn_in[5];
		dec_out.file_addr = insn_in[4:0];
		dec_out.imm = insn_in[8:0];
		if (insn_in[11:9] == `IBX_OPC_BRANCH) begin
			dec_out.op = IBX_OP_BRANCH;
		end else if (insn_in[11:8] == `IBX_OPC_OR_LIT) begin
			dec_out.op = IBX_OP_OR_LIT;
		end else if (insn_in[11:6] == `IBX_OPC_INCR_FILE) begin
			dec_out.op = IBX_OP_INCR_FILE;
		end else if (insn_in[11:6] == `IBX_OPC_INCR_SKIP) begin
			dec_out.op = IBX_OP_INCR_SKIP;
		end else if (insn_in[11:6] == `IBX_OPC_OR_FILE) begin
			dec_out.op = IBX_OP_OR_FILE;
		end
	end
endmodule : ibx_decode

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
	import ibx_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [11:0] insn = 12'h000;
	logic [7:0] rdata = 8'h00;
	logic [7:0] status = 8'h00;
	logic [4:0] raddr;
	ibx_fwr_type fwr;
	logic zwe, zval, flush;
	logic [7:0] acc;
	logic [10:0] pc, exp_pc;
	logic [11:0] exec;
	logic [43:0] rows [8];
	int fails = 0;
	int cmp_count = 0;
	ibx_core ibx_core_inst (.sys_clk_in(clk), .arst_n_in(arst_n),
		.fetch_insn_in(insn), .file_rdata_in(rdata), .status_in(status),
		.file_raddr_out(raddr), .file_wr_out(fwr), .zero_we_out(zwe),
		.zero_val_out(zval), .accum_out(acc), .pc_out(pc),
		.flush_out(flush), .exec_insn_out(exec));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [12:0] e, s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic step(input logic [11:0] i);
		insn = i;
		#1;
		if (!i[11]) chk("raddr", {8'h00, i[4:0]}, raddr);
		@(negedge clk);
		exp_pc = exp_pc + 11'h001;
	endtask : step
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		// Fields: insn, rdata, acc, we, addr, wdata, zero_we, zero_val
		rows[0] = {12'hD00, 8'h00, 8'h00, 1'b0, 5'h00, 8'h00, 2'b11};
		rows[1] = {12'hD5A, 8'h00, 8'h5A, 1'b0, 5'h00, 8'h00, 2'b10};
		rows[2] = {12'h283, 8'hFF, 8'h00, 1'b0, 5'h00, 8'h00, 2'b11};
		rows[3] = {12'h2BF, 8'h7F, 8'h00, 1'b1, 5'h1F, 8'h80, 2'b10};
		rows[4] = {12'h101, 8'h81, 8'h81, 1'b0, 5'h00, 8'h00, 2'b10};
		rows[5] = {12'h122, 8'h00, 8'h81, 1'b1, 5'h02, 8'h81, 2'b10};
		rows[6] = {12'h3C4, 8'h10, 8'h11, 1'b0, 5'h00, 8'h00, 2'b00};
		rows[7] = {12'h3E5, 8'h20, 8'h11, 1'b1, 5'h05, 8'h21, 2'b00};
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		exp_pc = 11'h7FF;
		for (int r = 0; r < 8; r++) begin
			rdata = rows[r][31:24];
			step(rows[r][43:32]);
			chk("acc", rows[r][23:16], acc);
			chk("we", rows[r][15], fwr.we);
			if (rows[r][15]) chk("wr", rows[r][14:2], {fwr.addr, fwr.data});
			chk("zwe", rows[r][1], zwe);
			if (rows[r][1]) chk("zval", rows[r][0], zval);
			chk("flush", 1'b0, flush);
			chk("pc", exp_pc, pc);
		end
		$display("table done");
		rdata = 8'hFF;
		step(12'h3C0);
		chk("acc", 8'h00, acc);
		chk("flush", 1'b1, flush);
		chk("exec", 12'h000, exec);
		chk("zwe", 1'b0, zwe);
		// Word fetched under flush must leave no trace
		step(12'hDFF);
		chk("acc", 8'h00, acc);
		chk("flush", 1'b0, flush);
		chk("pc", exp_pc, pc);
		$display("skip done");
		for (int b = 0; b < 2; b++) begin
			// Stray status bits prove only the page bits reach the counter
			status = b ? 8'hBF : 8'h40;
			step(b ? 12'hA00 : 12'hBFF);
			exp_pc = b ? 11'h200 : 11'h5FF;
			chk("pc", exp_pc, pc);
			chk("zwe", 1'b0, zwe);
			chk("flush", 1'b1, flush);
			step(12'hDFF);
			chk("acc", 8'h00, acc);
			chk("pc", exp_pc, pc);
		end
		$display("branch done");
		step(12'hD3C);
		chk("acc", 8'h3C, acc);
		arst_n = 1'b0;
		#1;
		chk("acc", 8'h00, acc);
		chk("pc", 11'h7FF, pc);
		chk("flush", 1'b0, flush);
		chk("zwe", 1'b0, zwe);
		// Release mid-run; first word may meet the first edge
		@(negedge clk);
		arst_n = 1'b1;
		exp_pc = 11'h7FF;
		step(12'hD81);
		chk("acc", 8'h81, acc);
		chk("zwe", 1'b1, zwe);
		chk("zval", 1'b0, zval);
		chk("pc", exp_pc, pc);
		$display("reset done");
		test_done();
	end
endmodule : tb
